// file: pkg/cfd_cfg.svh
`ifndef CFD_CFG_SVH
`define CFD_CFG_SVH
// register byte offsets
`define CFD_DIAG_ADDR      8'h00
`define CFD_MASK_ADDR      8'h04
`define CFD_CTRL_ADDR      8'h08
`define CFD_INT_STAT_ADDR  8'h0C
`define CFD_INT_MASK_ADDR  8'h10
// diagnostic and mask field positions
`define CFD_FF_BIT         15
`define CFD_POR_BIT        5
`define CFD_SE_BIT         4
`define CFD_VS_BIT         3
`define CFD_OT_BIT         2
`define CFD_TW_BIT         1
// control field positions
`define CFD_CTRL_DIRECT    0
`define CFD_CTRL_ESF       1
// interrupt event positions
`define CFD_EV_TW          0
`define CFD_EV_OT          1
`define CFD_EV_VS          2
`define CFD_EV_SE          3
// reset values
`define CFD_MASK_RST       16'h0000
`define CFD_CTRL_RST       2'h0
`define CFD_INT_MASK_RST   4'h0
// timing counts
`define CFD_PULSE_PERIODS  3'h4
`define CFD_FRAME_EDGES    5'h10
`endif

// file: pkg/cfd_pkg.sv
package cfd_pkg;
    // fault pulse sequencer states
    typedef enum logic [1:0] {
        CFD_IDLE     = 2'b00,
        CFD_ACTIVE   = 2'b01,
        CFD_INACTIVE = 2'b10
    } cfd_pulse_e;

    // register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cfd_bus_s;

    // raw pin inputs, asynchronous to the clock
    typedef struct packed {
        logic pwm;
        logic sck;
        logic strobe_n;
        logic vdd_low;
        logic vbb_below_off;
        logic vbb_above_on;
        logic ot_cmp;
        logic tw_cmp;
    } cfd_pins_s;
endpackage

// file: hdl/cfd_chip_fault.sv
`timescale 1ns/100ps
`include "cfd_cfg.svh"
// Summary of operation
// - each diagnostic masked by a one, except logic supply and serial error
// - masked diagnostic makes no fault state, no common flag, no bit
// - faults latch in diagnostic register, cleared by full serial read or reset
// - thermal warning sets its flag, takes no protective action
// - warning: low in direct; indirect four-on four-off if esf, else inactive
// - condition clear releases steady low at once, pulse at its end
// - overtemperature sets flag; direct or esf holds fault low, gates off
// - indirect overtemperature without esf disables nothing; four-on four-off
// - gates off until supply above on-threshold, stay on until off-threshold
// - supply undervoltage sets flag, holds fault low, ignores pwm input
// - undervoltage clear re-enables gates, releases fault, flag stays latched
// - supply undervoltage monitor disabled entirely by its mask bit
// - logic supply low disables outputs and resets all logic
// - leaving power-down restores registers, then sets common and reset flags
// - frame with not exactly sixteen clock edges cancels the write
// - serial error keeps diagnostics, sets common and serial error flags
// - pulse: low rest of period plus four periods, repeat with equal gap
// - bit 15 is common fault flag, set while any latched bit set
module cfd_chip_fault
    import cfd_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // register bus
    input  wire cfd_bus_s    bus,
    output logic [31:0]      rdata,
    // pins from the analog monitors, serial port and pwm
    input  wire cfd_pins_s   pins,
    // open-drain fault pin
    output logic             fault_out_n,
    output logic             fault_out_n_oe,
    // control toward the bridge and serial core
    output logic             gate_enable,
    output logic             pwm_accept,
    output logic             serial_write_ok,
    output logic [15:0]      diag_word,
    // interrupt
    output logic             irq
);
    // synchronised pins
    logic [7:0]  sync_a;
    logic [7:0]  sync_b;
    cfd_pins_s   pin_s;

    // two flops per pin, first stage read only by the second
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= pins[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate
    assign pin_s = cfd_pins_s'(sync_b);

    // registers and state
    logic        hold;
    logic        por_pend;
    logic [15:0] mask;
    logic [1:0]  ctrl;
    logic [3:0]  int_stat;
    logic [3:0]  int_mask;
    logic [5:1]  diag;
    logic        ff;
    logic        uv_state;
    logic        tw_q, ot_q, uv_q, pwm_q, sck_q, strb_q;
    logic [4:0]  edge_cnt;
    cfd_pulse_e  pst;
    logic [2:0]  pcnt;

    assign hold = pin_s.vdd_low;

    // live conditions after masking
    logic tw_live, ot_live, direct, stop_on_fault_enable;
    logic pwm_rise, sck_rise;
    logic frame_end, frame_good, frame_bad;
    assign tw_live    = pin_s.tw_cmp & ~mask[`CFD_TW_BIT];
    assign ot_live    = pin_s.ot_cmp & ~mask[`CFD_OT_BIT];
    assign direct     = ctrl[`CFD_CTRL_DIRECT];
    assign stop_on_fault_enable        = ctrl[`CFD_CTRL_ESF];
    assign pwm_rise   = pin_s.pwm & ~pwm_q;
    assign sck_rise   = pin_s.sck & ~sck_q & ~pin_s.strobe_n;
    assign frame_end  = pin_s.strobe_n & ~strb_q;
    assign frame_good = frame_end & (edge_cnt == `CFD_FRAME_EDGES);
    assign frame_bad  = frame_end & (edge_cnt != `CFD_FRAME_EDGES);

    // edge detectors and power-down pending flag
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tw_q     <= 1'b0;
            ot_q     <= 1'b0;
            uv_q     <= 1'b1; // matches uv_state after reset, no false event
            pwm_q    <= 1'b0;
            sck_q    <= 1'b0;
            strb_q   <= 1'b1;
            por_pend <= 1'b1;
        end else if (hold) begin
            tw_q     <= 1'b0;
            ot_q     <= 1'b0;
            uv_q     <= 1'b1;
            pwm_q    <= 1'b0;
            sck_q    <= 1'b0;
            strb_q   <= 1'b1;
            por_pend <= 1'b1;
        end else begin
            tw_q     <= tw_live;
            ot_q     <= ot_live;
            uv_q     <= uv_state;
            pwm_q    <= pin_s.pwm;
            sck_q    <= pin_s.sck;
            strb_q   <= pin_s.strobe_n;
            por_pend <= 1'b0;
        end
    end

    // supply undervoltage with two thresholds
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            uv_state <= 1'b1;
        end else if (hold) begin
            uv_state <= 1'b1;
        end else if (mask[`CFD_VS_BIT]) begin
            uv_state <= 1'b0;
        end else if (pin_s.vbb_below_off) begin
            uv_state <= 1'b1;
        end else if (pin_s.vbb_above_on) begin
            uv_state <= 1'b0;
        end
    end

    // serial frame edge counter, saturates at thirty-one
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            edge_cnt <= 5'h00;
        end else if (hold || pin_s.strobe_n) begin
            edge_cnt <= 5'h00;
        end else if (sck_rise && edge_cnt != 5'h1F) begin
            edge_cnt <= edge_cnt + 5'h01;
        end
    end

    // diagnostic latches, new faults win over the read clear
    logic [5:1] next_diag;
    always_comb begin
        next_diag = frame_good ? 5'h00 : diag;
        if (tw_live)
            next_diag[`CFD_TW_BIT] = 1'b1;
        if (ot_live)
            next_diag[`CFD_OT_BIT] = 1'b1;
        if (uv_state && !mask[`CFD_VS_BIT])
            next_diag[`CFD_VS_BIT] = 1'b1;
        if (frame_bad)
            next_diag[`CFD_SE_BIT] = 1'b1;
        if (por_pend)
            next_diag[`CFD_POR_BIT] = 1'b1;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            diag <= 5'h00;
            ff   <= 1'b0;
        end else if (hold) begin
            diag <= 5'h00;
            ff   <= 1'b0;
        end else begin
            diag <= next_diag;
            ff   <= |next_diag;
        end
    end

    // pulse sequencer stepping on pwm rising edges
    logic pulse_req;
    assign pulse_req = ~direct & ((ot_live & ~stop_on_fault_enable) | (tw_live & stop_on_fault_enable));
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pst  <= CFD_IDLE;
            pcnt <= 3'h0;
        end else if (hold) begin
            pst  <= CFD_IDLE;
            pcnt <= 3'h0;
        end else begin
            case (pst)
                CFD_IDLE: begin
                    if (pulse_req) begin
                        pst  <= CFD_ACTIVE;
                        pcnt <= 3'h0;
                    end
                end
                CFD_ACTIVE: begin
                    if (pwm_rise) begin
                        if (pcnt == `CFD_PULSE_PERIODS) begin
                            pst  <= CFD_INACTIVE;
                            pcnt <= 3'h0;
                        end else begin
                            pcnt <= pcnt + 3'h1;
                        end
                    end
                end
                CFD_INACTIVE: begin
                    if (!pulse_req) begin
                        pst <= CFD_IDLE;
                    end else if (pwm_rise) begin
                        if (pcnt == `CFD_PULSE_PERIODS - 3'h1) begin
                            pst  <= CFD_ACTIVE;
                            pcnt <= 3'h1; // entered on a rise, first period counted
                        end else begin
                            pcnt <= pcnt + 3'h1;
                        end
                    end
                end
                default: begin
                    pst  <= CFD_IDLE;
                    pcnt <= 3'h0;
                end
            endcase
        end
    end

    // fault pin, gate enable and pwm gating
    logic perm_low;
    assign perm_low = uv_state | (direct & (tw_live | ot_live)) | (ot_live & stop_on_fault_enable);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_out_n    <= 1'b0;
            fault_out_n_oe <= 1'b0;
            gate_enable    <= 1'b0;
            pwm_accept     <= 1'b0;
        end else if (hold) begin
            fault_out_n    <= 1'b0;
            fault_out_n_oe <= 1'b0;
            gate_enable    <= 1'b0;
            pwm_accept     <= 1'b0;
        end else begin
            fault_out_n    <= 1'b0;
            fault_out_n_oe <= perm_low | (pst == CFD_ACTIVE);
            gate_enable    <= ~uv_state & ~(ot_live & (direct | stop_on_fault_enable));
            pwm_accept     <= pin_s.pwm & ~uv_state;
        end
    end

    // serial outputs: write commit pulse and diagnostic word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_write_ok <= 1'b0;
            diag_word       <= 16'h0000;
        end else begin
            serial_write_ok <= frame_good & ~hold;
            diag_word       <= {ff, 9'h000, diag, 1'b0};
        end
    end

    // software registers: mask, control, interrupt mask
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask     <= `CFD_MASK_RST;
            ctrl     <= `CFD_CTRL_RST;
            int_mask <= `CFD_INT_MASK_RST;
        end else if (hold) begin
            mask     <= `CFD_MASK_RST;
            ctrl     <= `CFD_CTRL_RST;
            int_mask <= `CFD_INT_MASK_RST;
        end else if (bus.wr) begin
            if (bus.addr == `CFD_MASK_ADDR) begin
                mask <= bus.wdata[15:0] & 16'h000E;
            end else if (bus.addr == `CFD_CTRL_ADDR) begin
                ctrl <= bus.wdata[1:0];
            end else if (bus.addr == `CFD_INT_MASK_ADDR) begin
                int_mask <= bus.wdata[3:0];
            end
        end
    end

    // sticky interrupt status, set wins over write-one clear
    logic [3:0] ev;
    assign ev = {frame_bad, uv_state & ~uv_q, ot_live & ~ot_q, tw_live & ~tw_q};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            int_stat <= 4'h0;
            irq      <= 1'b0;
        end else if (hold) begin
            int_stat <= 4'h0;
            irq      <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == `CFD_INT_STAT_ADDR)
                int_stat <= (int_stat & ~bus.wdata[3:0]) | ev;
            else
                int_stat <= int_stat | ev;
            irq <= |(int_stat & ~int_mask);
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            if (bus.addr == `CFD_DIAG_ADDR)
                rdata <= {16'h0000, ff, 9'h000, diag, 1'b0};
            else if (bus.addr == `CFD_MASK_ADDR)
                rdata <= {16'h0000, mask};
            else if (bus.addr == `CFD_CTRL_ADDR)
                rdata <= {30'h0000_0000, ctrl};
            else if (bus.addr == `CFD_INT_STAT_ADDR)
                rdata <= {28'h000_0000, int_stat};
            else if (bus.addr == `CFD_INT_MASK_ADDR)
                rdata <= {28'h000_0000, int_mask};
            else
                rdata <= 32'h0000_0000;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // checks
    a_tw_mask_holds: assert property (@(posedge clock) disable iff (rst)
        mask[`CFD_TW_BIT] && !diag[`CFD_TW_BIT] && !frame_bad |=> !diag[`CFD_TW_BIT])
        else $error("masked warning set its bit");
    a_serial_err_set: assert property (@(posedge clock) disable iff (rst)
        frame_bad && !hold |=> diag[`CFD_SE_BIT] && ff)
        else $error("bad frame did not flag serial error");
    a_read_clears_diag: assert property (@(posedge clock) disable iff (rst)
        frame_good && !hold && !tw_live && !ot_live && !uv_state && !por_pend
        |=> diag == 5'h00)
        else $error("complete read left diagnostics set");
    a_ff_tracks_bits: assert property (@(posedge clock) disable iff (rst)
        ff == (|diag))
        else $error("common flag disagrees with latched bits");
    a_ot_stops_gates: assert property (@(posedge clock) disable iff (rst)
        ot_live && (direct || stop_on_fault_enable) && !hold |=> !gate_enable && fault_out_n_oe)
        else $error("overtemperature did not stop gates");
    a_ot_no_action: assert property (@(posedge clock) disable iff (rst)
        ot_live && !stop_on_fault_enable && !direct && !uv_state && !hold |=> gate_enable)
        else $error("overtemperature without esf disabled gates");
    a_uv_holds_low: assert property (@(posedge clock) disable iff (rst)
        uv_state && !hold |=> fault_out_n_oe && !pwm_accept && !gate_enable)
        else $error("undervoltage did not hold fault low");
    a_tw_direct_low: assert property (@(posedge clock) disable iff (rst)
        tw_live && direct && !hold |=> fault_out_n_oe)
        else $error("direct warning did not drive fault low");
    a_pulse_length: assert property (@(posedge clock) disable iff (rst)
        pst == CFD_ACTIVE && pwm_rise && pcnt == `CFD_PULSE_PERIODS && !hold
        |=> pst == CFD_INACTIVE)
        else $error("pulse ended at the wrong period");
    a_por_flag_set: assert property (@(posedge clock) disable iff (rst)
        $fell(hold) |-> ##[1:2] (diag[`CFD_POR_BIT] && ff))
        else $error("power-down exit did not set reset flag");
    a_hold_kills_out: assert property (@(posedge clock) disable iff (rst)
        hold |=> !fault_out_n_oe && !gate_enable)
        else $error("outputs active during logic supply low");

    c_pulse_gap:  cover property (@(posedge clock) disable iff (rst)
        pst == CFD_ACTIVE ##1 pst == CFD_INACTIVE);
    c_good_frame: cover property (@(posedge clock) disable iff (rst) frame_good);
    c_bad_frame:  cover property (@(posedge clock) disable iff (rst) frame_bad);
    c_uv_release: cover property (@(posedge clock) disable iff (rst) $fell(uv_state));
endmodule // cfd_chip_fault

// file: testbench/cfd_host_model.sv
`timescale 1ns/100ps
// host side: drives pwm, sees the open-drain fault line through a pull-up
module cfd_host_model #(
    parameter int HALF = 10
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // fault pin from the device
    input  wire logic fault_out_n,
    input  wire logic fault_out_n_oe,
    // pwm and observation
    output logic      pwm,
    output logic      fault_line,
    output int        rises
);
    int ph;

    // pull-up wins while the device releases the pin
    assign fault_line = fault_out_n_oe ? fault_out_n : 1'b1;

    // free-running pwm, half period of HALF cycles
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ph  <= 0;
            pwm <= 1'b0;
        end else if (ph == HALF - 1) begin
            ph  <= 0;
            pwm <= ~pwm;
        end else begin
            ph <= ph + 1;
        end
    end

    // rising pwm edges, the unit of pulse timing
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rises <= 0;
        end else if (ph == HALF - 1 && !pwm) begin
            rises <= rises + 1;
        end
    end
endmodule // cfd_host_model

// file: testbench/testbench.sv
`timescale 1ns/100ps
`include "cfd_cfg.svh"
// self-checking bench for the chip fault block
module testbench;
    import cfd_pkg::*;
    // clock, reset, bus
    logic        clock;
    logic        rst;
    cfd_bus_s    bus;
    logic [31:0] rdata;
    logic [31:0] v;
    // pins and outputs
    logic        sck, strobe_n, vdd_low, below, above, ot, tw;
    cfd_pins_s   pins;
    logic        pwm, fline, oe, fo_n, gate, pacc, wok, irq;
    logic [15:0] diag;
    int          rises;
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;

    assign pins = {pwm, sck, strobe_n, vdd_low, below, above, ot, tw};

    cfd_chip_fault uut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .pins(pins),
        .fault_out_n(fo_n), .fault_out_n_oe(oe), .gate_enable(gate), .pwm_accept(pacc),
        .serial_write_ok(wok), .diag_word(diag), .irq(irq));
    cfd_host_model host (.clock(clock), .rst(rst), .fault_out_n(fo_n),
        .fault_out_n_oe(oe), .pwm(pwm), .fault_line(fline), .rises(rises));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    // serial frame of n clock rises; ok tells whether the write was taken
    task automatic frame(input int n, output logic ok);
        @(posedge clock);
        strobe_n <= 1'b0;
        repeat (n) begin
            repeat (4) @(posedge clock);
            sck <= 1'b1;
            repeat (4) @(posedge clock);
            sck <= 1'b0;
        end
        repeat (4) @(posedge clock);
        strobe_n <= 1'b1;
        ok = 1'b0;
        repeat (8) begin
            @(posedge clock);
            #1 if (wok === 1'b1) ok = 1'b1;
        end
    endtask

    task automatic clean();
        logic ok;
        frame(16, ok);
        chk("write_ok", ok, 1'b1);
    endtask

    // bounded wait for the pin enable
    task automatic wait_oe(input logic val);
        int k;
        k = 0;
        while (oe !== val && k < 400) begin
            @(posedge clock);
            #1 k++;
        end
    endtask

    task automatic t_reset();
        rd(`CFD_DIAG_ADDR);
        chk("diag_por", v & 32'h0000_8020, 32'h0000_8020);
        chk("gate_uv", gate, 1'b0);
        chk("fault_uv", fline, 1'b0);
        rd(`CFD_CTRL_ADDR);
        chk("ctrl_rst", v, 32'h0000_0000);
        rd(`CFD_INT_MASK_ADDR);
        chk("imask_rst", v, 32'h0000_0000);
        rd(8'h20);
        chk("unmapped", v, 32'h0000_0000);
        wr(`CFD_MASK_ADDR, 32'h0000_FFFF);
        rd(`CFD_MASK_ADDR);
        chk("mask_bits", v, 32'h0000_000E);
        wr(`CFD_MASK_ADDR, 32'h0000_0000);
        @(posedge clock);
        below <= 1'b0;
        above <= 1'b1;
        tick(5);
        chk("gate_on", gate, 1'b1);
    endtask

    task automatic t_uv();
        int k;
        clean();
        @(posedge clock);
        above <= 1'b0;
        tick(5);
        chk("gate_hyst_on", gate, 1'b1);
        @(posedge clock);
        below <= 1'b1;
        tick(5);
        chk("gate_uv_off", gate, 1'b0);
        chk("fault_uv_low", fline, 1'b0);
        k = 0;
        repeat (60) begin
            @(posedge clock);
            #1 if (pacc !== 1'b0) k++;
        end
        chk("pwm_ignored", k, 0);
        @(posedge clock);
        below <= 1'b0;
        tick(5);
        chk("gate_hyst_off", gate, 1'b0);
        @(posedge clock);
        above <= 1'b1;
        tick(5);
        chk("gate_back", gate, 1'b1);
        chk("fault_back", fline, 1'b1);
        k = 0;
        repeat (40) begin
            @(posedge clock);
            #1 if (pacc === 1'b1) k++;
        end
        chk("pwm_follows", k, 20);
        rd(`CFD_DIAG_ADDR);
        chk("diag_vs", v, 32'h0000_8008);
        chk("diag_word", {16'h0000, diag}, 32'h0000_8008);
        clean();
        wr(`CFD_MASK_ADDR, 32'h0000_0008);
        @(posedge clock);
        above <= 1'b0;
        below <= 1'b1;
        tick(5);
        chk("gate_vs_mask", gate, 1'b1);
        chk("fault_vs_mask", fline, 1'b1);
        @(posedge clock);
        above <= 1'b1;
        below <= 1'b0;
        tick(5);
        wr(`CFD_MASK_ADDR, 32'h0000_0000);
        rd(`CFD_DIAG_ADDR);
        chk("diag_vs_masked", v, 32'h0000_0000);
    endtask

    task automatic t_tw();
        logic ok;
        int   k;
        wr(`CFD_CTRL_ADDR, 32'h0000_0001);
        @(posedge clock);
        tw <= 1'b1;
        tick(5);
        chk("tw_direct_low", fline, 1'b0);
        chk("tw_gate", gate, 1'b1);
        @(posedge clock);
        tw <= 1'b0;
        tick(4);
        chk("tw_release", fline, 1'b1);
        rd(`CFD_DIAG_ADDR);
        chk("tw_latched", v, 32'h0000_8002);
        frame(15, ok);
        chk("short_frame", ok, 1'b0);
        rd(`CFD_DIAG_ADDR);
        chk("se_kept", v, 32'h0000_8012);
        clean();
        wr(`CFD_MASK_ADDR, 32'h0000_0002);
        @(posedge clock);
        tw <= 1'b1;
        tick(5);
        chk("tw_masked_pin", fline, 1'b1);
        rd(`CFD_DIAG_ADDR);
        chk("tw_masked_bit", v, 32'h0000_0000);
        wr(`CFD_CTRL_ADDR, 32'h0000_0000);
        wr(`CFD_MASK_ADDR, 32'h0000_0000);
        k = 0;
        repeat (60) begin
            @(posedge clock);
            #1 if (fline !== 1'b1) k++;
        end
        chk("tw_indirect_quiet", k, 0);
        wr(`CFD_CTRL_ADDR, 32'h0000_0002);
        wait_oe(1'b1);
        chk("tw_esf_pulse", oe, 1'b1);
        @(posedge clock);
        tw <= 1'b0;
        wait_oe(1'b0);
        chk("tw_pulse_end", oe, 1'b0);
    endtask

    task automatic t_ot();
        int r0;
        int k;
        wr(`CFD_CTRL_ADDR, 32'h0000_0000);
        @(posedge pwm);
        repeat (3) @(posedge clock);
        ot <= 1'b1;
        wait_oe(1'b1);
        r0 = rises;
        chk("ot_gate_esf0", gate, 1'b1);
        wait_oe(1'b0);
        chk("ot_active_len", rises - r0, 5);
        r0 = rises;
        wait_oe(1'b1);
        chk("ot_gap_len", rises - r0, 4);
        r0 = rises;
        @(posedge clock);
        ot <= 1'b0;
        wait_oe(1'b0);
        chk("ot_pulse_end", rises - r0, 4);
        wr(`CFD_CTRL_ADDR, 32'h0000_0002);
        @(posedge clock);
        ot <= 1'b1;
        tick(5);
        k = 0;
        repeat (100) begin
            @(posedge clock);
            #1 if (oe !== 1'b1 || gate !== 1'b0) k++;
        end
        chk("ot_esf_hold", k, 0);
        @(posedge clock);
        ot <= 1'b0;
        tick(4);
        chk("ot_release", oe, 1'b0);
        chk("ot_gate_back", gate, 1'b1);
        rd(`CFD_DIAG_ADDR);
        chk("ot_flag", v & 32'h0000_8004, 32'h0000_8004);
    endtask

    task automatic t_serr();
        logic ok;
        clean();
        wr(`CFD_INT_STAT_ADDR, 32'h0000_000F);
        frame(17, ok);
        chk("long_frame", ok, 1'b0);
        rd(`CFD_DIAG_ADDR);
        chk("se_flag", v, 32'h0000_8010);
        chk("irq_set", irq, 1'b1);
        wr(`CFD_INT_MASK_ADDR, 32'h0000_0008);
        tick(2);
        chk("irq_masked", irq, 1'b0);
        wr(`CFD_INT_MASK_ADDR, 32'h0000_0000);
        wr(`CFD_INT_STAT_ADDR, 32'h0000_0008);
        tick(2);
        chk("irq_cleared", irq, 1'b0);
    endtask

    task automatic t_pdown();
        wr(`CFD_CTRL_ADDR, 32'h0000_0003);
        @(posedge clock);
        vdd_low <= 1'b1;
        ot <= 1'b1;
        tick(5);
        chk("pd_gate", gate, 1'b0);
        chk("pd_fault", oe, 1'b0);
        @(posedge clock);
        vdd_low <= 1'b0;
        ot <= 1'b0;
        tick(5);
        rd(`CFD_CTRL_ADDR);
        chk("pd_ctrl", v, 32'h0000_0000);
        rd(`CFD_DIAG_ADDR);
        chk("pd_por", v & 32'h0000_8020, 32'h0000_8020);
    endtask

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // main sequence
    initial begin
        rst = 1'b1;
        bus = '0;
        sck = 1'b0;
        strobe_n = 1'b1;
        vdd_low = 1'b0;
        below = 1'b1;
        above = 1'b0;
        ot = 1'b0;
        tw = 1'b0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        tick(3);
        t_reset();
        t_uv();
        t_tw();
        t_ot();
        t_serr();
        t_pdown();
        conclude();
    end

    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            conclude();
        end
    end
endmodule // testbench
